// file: hdl/sec_pkg.sv
// Package for the serial memory command front end: opcodes, status layout,
// protection ranges and the struct that carries array write requests.
// Assumes a single system clock domain; the serial pins are sampled in it.
package sec_pkg;

  localparam logic [7:0] SEC_OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] SEC_OP_SET_USER_FLAG   = 8'h00;
  localparam logic [7:0] SEC_OP_CLEAR_LATCH     = 8'h04;
  localparam logic [7:0] SEC_OP_READ_STATUS     = 8'h05;
  localparam logic [7:0] SEC_OP_WRITE_STATUS    = 8'h01;
  localparam logic [7:0] SEC_OP_READ_ARRAY      = 8'h03;
  localparam logic [7:0] SEC_OP_WRITE_ARRAY     = 8'h02;

  localparam int SEC_BIT_LOCK_EN = 7;
  localparam int SEC_BIT_FLAG    = 6;
  localparam int SEC_BIT_FIX_HI  = 5;
  localparam int SEC_BIT_FIX_LO  = 4;
  localparam int SEC_BIT_BL_HI   = 3;
  localparam int SEC_BIT_BL_LO   = 2;
  localparam int SEC_BIT_WEL     = 1;
  localparam int SEC_BIT_BUSY    = 0;

  localparam logic [15:0] SEC_QUARTER_BASE = 16'h0C00;
  localparam logic [15:0] SEC_HALF_BASE    = 16'h0800;
  localparam logic [15:0] SEC_ALL_BASE     = 16'h0000;
  localparam logic [15:0] SEC_ARRAY_TOP    = 16'h0FFF;

  localparam logic [1:0] SEC_BL_NONE    = 2'h0;
  localparam logic [1:0] SEC_BL_QUARTER = 2'h1;
  localparam logic [1:0] SEC_BL_HALF    = 2'h2;

  localparam int SEC_ADDR_BITS = 16;
  localparam int SEC_CMD_BITS  = 8;

  // Default length of a nonvolatile write in system clocks.
  localparam int SEC_WRITE_CYCLES = 1000;

  typedef enum logic [2:0] {
    SEC_ST_OPCODE  = 3'b000,
    SEC_ST_ADDRESS = 3'b001,
    SEC_ST_DATA    = 3'b011,
    SEC_ST_STATUS  = 3'b010,
    SEC_ST_IGNORE  = 3'b110
  } sec_state_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } sec_write_s;

endpackage : sec_pkg

// file: hdl/sec_spi_front.sv
// SPI mode 0/3 command front end of a serial EEPROM with write protection.
// Assumes the serial pins come from another domain and are sampled here.
//
// Function
// - Sample serial input on serial clock rising edges.
// - Change serial output only on falling edges.
// - All bytes move most significant bit first.
// - First bit taken after chip select falls.
// - Halted serial clock resumes at same bit.
// - Opcode collected in eight-bit instruction register.
// - Set opcode sets latch; clear clears latch, flag.
// - No write without write enable latch set.
// - Latch cleared at power-up and after writes, unless a set lands on the last busy cycle.
// - Read status opcode works even while busy.
// - Status byte layout: lock, flag, ones, field, latch, busy.
// - Busy bit read-only, one during nonvolatile write.
// - Latch bit read-only, shows latch state.
// - Flag opcode sets volatile user flag.
// - User flag cleared at power-up.
// - Status write sets field, lock, flag.
// - Read opcode reads array from sent address.
// - Write opcode writes array at sent address.
// - Block field protects quarter, half or all.
// - Protected locations readable, writes rejected.
// - Status write refused if pin low, lock set.
// - Sixteen-bit address follows read or write.
// - Read address increments and wraps to zero.
// - Latch-set opcode needs chip select rise.
// - Array write starts only on byte boundary.
`timescale 1ns/10ps
`default_nettype none
module sec_spi_front
  import sec_pkg::*;
#(
  parameter int WRITE_CYCLES = SEC_WRITE_CYCLES,
  parameter int DEPTH        = 4096,
  parameter int PAGE_BYTES   = 32
)(
  // System.
  input  wire logic clock,
  input  wire logic resetn,
  // Serial pins.
  input  wire logic cs_n_pin,
  input  wire logic sck_pin,
  input  wire logic si_pin,
  input  wire logic wp_n_pin,
  output logic      so_out,
  output logic      so_oe,
  // Status view.
  output logic [7:0] protect_status_byte
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = $clog2(PAGE_BYTES);

  initial
  begin
    if (WRITE_CYCLES < 1 || DEPTH < 2 || DEPTH > 65536 ||
        PAGE_BYTES < 2 || PAGE_BYTES > DEPTH)
      $error("sec_spi_front: unsupported parameter values");
  end

  logic [2:0] cs_sync_r, sck_sync_r, si_sync_r, wp_sync_r;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_sync_r  <= 3'h7;
      sck_sync_r <= 3'h0;
      si_sync_r  <= 3'h0;
      wp_sync_r  <= 3'h7;
    end
    else
    begin
      cs_sync_r  <= {cs_sync_r[1:0], cs_n_pin};
      sck_sync_r <= {sck_sync_r[1:0], sck_pin};
      si_sync_r  <= {si_sync_r[1:0], si_pin};
      wp_sync_r  <= {wp_sync_r[1:0], wp_n_pin};
    end
  end

  // A level counts once the second and third stages agree.
  logic cs_n_r, sck_r, si_r, wp_n_r, sck_prev_r, cs_prev_r;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_n_r     <= 1'b1;
      sck_r      <= 1'b0;
      si_r       <= 1'b0;
      wp_n_r     <= 1'b1;
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
    end
    else
    begin
      if (cs_sync_r[1] == cs_sync_r[2])
        cs_n_r <= cs_sync_r[2];
      if (sck_sync_r[1] == sck_sync_r[2])
        sck_r <= sck_sync_r[2];
      if (si_sync_r[1] == si_sync_r[2])
        si_r <= si_sync_r[2];
      if (wp_sync_r[1] == wp_sync_r[2])
        wp_n_r <= wp_sync_r[2];
      sck_prev_r <= sck_r;
      cs_prev_r  <= cs_n_r;
    end
  end

  logic rise, fall, cs_end;
  // Edges only count while selected; a halted clock simply holds state.
  assign rise   = !cs_n_r && sck_r && !sck_prev_r;
  assign fall   = !cs_n_r && !sck_r && sck_prev_r;
  assign cs_end = cs_n_r && !cs_prev_r;

  function automatic logic sec_protected(input logic [1:0] bl,
                                         input logic [15:0] a);
    unique case (bl)
      SEC_BL_NONE:    sec_protected = 1'b0;
      SEC_BL_QUARTER: sec_protected = a >= SEC_QUARTER_BASE
                                      && a <= SEC_ARRAY_TOP;
      SEC_BL_HALF:    sec_protected = a >= SEC_HALF_BASE
                                      && a <= SEC_ARRAY_TOP;
      default:        sec_protected = a >= SEC_ALL_BASE;
    endcase
  endfunction : sec_protected

  logic [7:0]  mem [DEPTH];
  sec_state_e  state_r;
  logic [7:0]  shift_r;
  logic [2:0]  bit_r;
  logic [15:0] addr_r;
  logic [4:0]  addr_cnt_r;
  logic [7:0]  op_r;
  logic [7:0]  out_r;
  logic        wel_r, flag_r, lock_en_r, busy_r;
  logic [1:0]  bl_r;
  logic        extra_r;
  logic        byte_done_r;
  logic        pend_stat_r;
  logic [7:0]  pend_stat_data_r;
  logic [7:0]  page_data_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask_r;
  logic [15:0] page_base_r;
  logic [PW-1:0] page_ptr_r;
  logic        so_r, so_oe_r;
  logic [31:0] busy_cnt_r;

  logic [7:0] sb;
  assign sb = {lock_en_r, flag_r, 1'b1, 1'b1, bl_r, wel_r, busy_r};
  assign protect_status_byte = sb;

  logic [7:0] shifted;
  assign shifted = {shift_r[6:0], si_r};

  // Serial command engine.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= SEC_ST_OPCODE;
      shift_r     <= 8'h00;
      bit_r       <= 3'h0;
      op_r        <= 8'h00;
      addr_r      <= 16'h0000;
      addr_cnt_r  <= 5'h00;
      out_r       <= 8'h00;
      extra_r     <= 1'b0;
      byte_done_r <= 1'b0;
      page_ptr_r  <= '0;
      page_base_r <= 16'h0000;
      page_mask_r <= '0;
    end
    else if (cs_n_r)
    begin
      state_r     <= SEC_ST_OPCODE;
      bit_r       <= 3'h0;
      addr_cnt_r  <= 5'h00;
      extra_r     <= 1'b0;
      byte_done_r <= 1'b0;
    end
    else if (rise)
    begin
      shift_r     <= shifted;
      bit_r       <= bit_r + 3'h1;
      byte_done_r <= bit_r == 3'h7;
      unique case (state_r)
        SEC_ST_OPCODE:
          if (bit_r == 3'h7)
          begin
            op_r <= shifted;
            unique case (shifted)
              SEC_OP_READ_ARRAY, SEC_OP_WRITE_ARRAY:
                state_r <= busy_r ? SEC_ST_IGNORE : SEC_ST_ADDRESS;
              SEC_OP_READ_STATUS:
              begin
                state_r <= SEC_ST_STATUS;
                out_r   <= sb;
              end
              SEC_OP_WRITE_STATUS:
                state_r <= busy_r ? SEC_ST_IGNORE : SEC_ST_DATA;
              SEC_OP_SET_WRITE_LATCH, SEC_OP_CLEAR_LATCH,
              SEC_OP_SET_USER_FLAG:
                state_r <= SEC_ST_IGNORE;
              default:
                state_r <= SEC_ST_IGNORE;
            endcase
          end
        SEC_ST_ADDRESS:
        begin
          addr_r     <= {addr_r[14:0], si_r};
          addr_cnt_r <= addr_cnt_r + 5'h01;
          if (addr_cnt_r == 5'(SEC_ADDR_BITS - 1))
          begin
            state_r <= (op_r == SEC_OP_READ_ARRAY)
                       ? SEC_ST_STATUS : SEC_ST_DATA;
            out_r       <= mem[AW'({addr_r[14:0], si_r})];
            page_base_r <= {addr_r[14:0], si_r};
            page_ptr_r  <= PW'({addr_r[14:0], si_r});
            // The mask must outlive chip select so the commit can use it.
            page_mask_r <= '0;
          end
        end
        SEC_ST_DATA:
          if (bit_r == 3'h7)
          begin
            if (op_r == SEC_OP_WRITE_STATUS)
              extra_r <= 1'b1;
            else
            begin
              page_data_r[page_ptr_r] <= shifted;
              page_mask_r[page_ptr_r] <= 1'b1;
              page_ptr_r              <= page_ptr_r + 1'b1;
            end
          end
        SEC_ST_STATUS:
          if (bit_r == 3'h7)
          begin
            if (op_r == SEC_OP_READ_ARRAY)
            begin
              addr_r <= addr_r + 16'h0001;
              out_r  <= mem[AW'(addr_r + 16'h0001)];
            end
            else
              out_r <= sb;
          end
          else
            out_r <= {out_r[6:0], 1'b0};
        SEC_ST_IGNORE:
          extra_r <= 1'b1;
        default:
          ;
      endcase
    end
  end

  // Serial output is updated only on falling edges.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else if (cs_n_r)
    begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else if (fall && state_r == SEC_ST_STATUS)
    begin
      so_r    <= out_r[7];
      so_oe_r <= 1'b1;
    end
    else if (state_r == SEC_ST_IGNORE)
      so_oe_r <= 1'b0;
  end
  assign so_out = so_r;
  assign so_oe  = so_oe_r;

  // Command completion is judged when chip select rises.
  logic complete_byte, op_only, do_arr, do_stat, stat_ok, set_wel;
  assign complete_byte = byte_done_r && bit_r == 3'h0;
  assign op_only = state_r == SEC_ST_IGNORE && complete_byte
                   && addr_cnt_r == 5'h00 && !extra_r;
  assign set_wel = cs_end && op_only && op_r == SEC_OP_SET_WRITE_LATCH;
  assign stat_ok = !(lock_en_r && !wp_n_r);
  assign do_arr  = cs_end && state_r == SEC_ST_DATA
                   && op_r == SEC_OP_WRITE_ARRAY && complete_byte
                   && |page_mask_r && wel_r;
  assign do_stat = cs_end && state_r == SEC_ST_DATA
                   && op_r == SEC_OP_WRITE_STATUS && extra_r
                   && complete_byte && wel_r && stat_ok;

  // Volatile latches and nonvolatile status bits.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wel_r            <= 1'b0;
      flag_r           <= 1'b0;
      lock_en_r        <= 1'b0;
      bl_r             <= SEC_BL_NONE;
      busy_r           <= 1'b0;
      busy_cnt_r       <= 32'h0;
      pend_stat_r      <= 1'b0;
      pend_stat_data_r <= 8'h00;
    end
    else
    begin
      if (set_wel)
        wel_r <= 1'b1;
      else if (cs_end && op_only && op_r == SEC_OP_CLEAR_LATCH)
      begin
        wel_r  <= 1'b0;
        flag_r <= 1'b0;
      end
      else if (cs_end && op_only && op_r == SEC_OP_SET_USER_FLAG)
        flag_r <= 1'b1;
      if (do_arr || do_stat)
      begin
        busy_r           <= 1'b1;
        busy_cnt_r       <= 32'(WRITE_CYCLES);
        pend_stat_r      <= do_stat;
        pend_stat_data_r <= shift_r;
        if (do_stat)
          flag_r <= shift_r[SEC_BIT_FLAG];
      end
      else if (busy_r)
      begin
        busy_cnt_r <= busy_cnt_r - 32'h1;
        if (busy_cnt_r == 32'h1)
        begin
          busy_r <= 1'b0;
          // A latch set in the same cycle wins over the clear.
          if (!set_wel)
            wel_r <= 1'b0;
          if (pend_stat_r)
          begin
            lock_en_r <= pend_stat_data_r[SEC_BIT_LOCK_EN];
            bl_r <= pend_stat_data_r[SEC_BIT_BL_HI:SEC_BIT_BL_LO];
          end
        end
      end
    end
  end

  // Array commit at the end of the write time, skipping locked bytes.
  always_ff @(posedge clock)
  begin
    if (busy_r && busy_cnt_r == 32'h1 && !pend_stat_r)
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (page_mask_r[i] &&
            !sec_protected(bl_r, (page_base_r & ~16'(PAGE_BYTES - 1))
                                 | 16'(i)))
          mem[AW'((page_base_r & ~16'(PAGE_BYTES - 1)) | 16'(i))]
            <= page_data_r[i];
      end
  end

endmodule : sec_spi_front
`default_nettype wire

// file: tb/sec_spi_front_checker.sv
// Checker on the ports of the serial memory front end.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module sec_spi_front_checker
#(
  parameter int WRITE_CYCLES = 1000
)(
  // System.
  input wire logic       clock,
  input wire logic       resetn,
  // Serial pins.
  input wire logic       cs_n_pin,
  input wire logic       sck_pin,
  input wire logic       si_pin,
  input wire logic       wp_n_pin,
  input wire logic       so_out,
  input wire logic       so_oe,
  // Status view.
  input wire logic [7:0] protect_status_byte
);
  wire logic [7:0] s = protect_status_byte;
  int              busy_cnt_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= s[0] ? busy_cnt_r + 1 : 0;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence desel_s;
    cs_n_pin [*8];
  endsequence
  sequence busy_end_s;
    $fell(s[0]);
  endsequence

  AST_FIXED_ONES : assert property (
    s[5:4] == 2'b11) else $error("fixed bits wrong");
  AST_OE_IDLE : assert property (
    desel_s |-> !so_oe) else $error("output on while deselected");
  AST_SO_ON_FALL : assert property (
    $changed(so_out) && so_oe && $past(so_oe) |-> !sck_pin)
    else $error("output moved with clock high");
  AST_WEL_AT_DESEL : assert property (
    $rose(s[1]) |-> cs_n_pin) else $error("latch set while selected");
  AST_BUSY_NEEDS_WEL : assert property (
    $rose(s[0]) |-> cs_n_pin && $past(s[1]))
    else $error("write began without latch");
  AST_BUSY_CLR_WEL : assert property (
    busy_end_s |-> ##[0:2] !s[1]) else $error("latch kept after write");
  AST_BUSY_LEN : assert property (
    busy_end_s |-> busy_cnt_r inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]})
    else $error("write length wrong");
  AST_LOCK_AT_END : assert property (
    $changed({s[7], s[3:2]}) |-> $past(s[0]) && !s[0])
    else $error("lock bits moved outside write end");
endmodule : sec_spi_front_checker
`default_nettype wire

// file: tb/sec_spi_host.sv
// Mode 0 host model that drives chip select, serial clock and data in.
// Assumes the bench clock; pins change at its rising edge.
`timescale 1ns/10ps
`default_nettype none
module sec_spi_host
(
  // System.
  input  wire logic clock,
  // Serial pins.
  output var logic  cs_n_pin = 1'b1,
  output var logic  sck_pin = 1'b0,
  output var logic  si_pin = 1'b0,
  input  wire logic so_out
);
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk

  task automatic sel();
    cs_n_pin <= 1'b0;
    wait_clk(8);
  endtask : sel

  task automatic desel();
    wait_clk(4);
    cs_n_pin <= 1'b1;
    si_pin   <= ~si_pin;
    wait_clk(16);
  endtask : desel

  // The serial clock period is 31 system clocks, close to 125 ns.
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--)
    begin
      @(posedge clock);
      si_pin <= tx[i];
      wait_clk(15);
      rx = {rx[6:0], so_out};
      sck_pin <= 1'b1;
      wait_clk(15);
      sck_pin <= 1'b0;
    end
  endtask : xfer
endmodule : sec_spi_host
`default_nettype wire

// file: tb/tb_spi_eeprom_command_protect.sv
// Bench for the serial memory front end, driven through the host model.
// Assumes the design package is compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_spi_eeprom_command_protect;
  import sec_pkg::*;
  localparam int WCYC = 600;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic       wp_n_pin = 1'b1;
  logic       cs_n_pin;
  logic       sck_pin;
  logic       si_pin;
  logic       so_out;
  logic       so_oe;
  logic [7:0] st;
  logic [7:0] rx;
  int         fail_count = 0;
  int         num_checks = 0;

  always #2 clock = ~clock;

  sec_spi_front #(.WRITE_CYCLES(WCYC)) sec_spi_front_i (
    .clock(clock), .resetn(resetn), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .si_pin(si_pin), .wp_n_pin(wp_n_pin),
    .so_out(so_out), .so_oe(so_oe), .protect_status_byte(st));
  sec_spi_host sec_spi_host_i (
    .clock(clock), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .so_out(so_out));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_st(input logic [7:0] exp);
    #1;
    chk(st, exp);
  endtask : chk_st

  task automatic final_report();
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic tx8(input logic [7:0] b);
    sec_spi_host_i.xfer(b, 8, rx);
  endtask : tx8

  task automatic cmd1(input logic [7:0] op);
    sec_spi_host_i.sel();
    tx8(op);
    sec_spi_host_i.desel();
  endtask : cmd1

  task automatic wait_idle();
    for (int i = 0; i < 2000 && st[0] !== 1'b0; i++)
      @(posedge clock);
    if (st[0] !== 1'b0)
    begin
      chk({7'h00, st[0]}, 8'h00);
      final_report();
    end
  endtask : wait_idle

  // A nonzero n adds n bits of a trailing partial byte.
  task automatic wr_raw(input logic pre, input logic [15:0] a,
                        input logic [7:0] d, input int n);
    sec_spi_host_i.sel();
    if (pre)
      tx8(SEC_OP_SET_WRITE_LATCH);
    tx8(SEC_OP_WRITE_ARRAY);
    tx8(a[15:8]);
    tx8(a[7:0]);
    tx8(d);
    if (n > 0)
      sec_spi_host_i.xfer(8'hFF, n, rx);
    sec_spi_host_i.desel();
  endtask : wr_raw

  task automatic wr_arr(input logic [15:0] a, input logic [7:0] d);
    cmd1(SEC_OP_SET_WRITE_LATCH);
    wr_raw(1'b0, a, d, 0);
    wait_idle();
  endtask : wr_arr

  task automatic wr_stat(input logic [7:0] d);
    cmd1(SEC_OP_SET_WRITE_LATCH);
    sec_spi_host_i.sel();
    tx8(SEC_OP_WRITE_STATUS);
    tx8(d);
    sec_spi_host_i.desel();
    wait_idle();
  endtask : wr_stat

  task automatic rd_st(input logic [7:0] e);
    sec_spi_host_i.sel();
    tx8(SEC_OP_READ_STATUS);
    tx8(8'h00);
    chk(rx, e);
    sec_spi_host_i.desel();
  endtask : rd_st

  task automatic rd2(input logic [15:0] a, input logic [7:0] e0,
                     input logic [7:0] e1);
    sec_spi_host_i.sel();
    tx8(SEC_OP_READ_ARRAY);
    tx8(a[15:8]);
    tx8(a[7:0]);
    sec_spi_host_i.wait_clk(200);
    tx8(8'h00);
    chk(rx, e0);
    tx8(8'h00);
    chk(rx, e1);
    sec_spi_host_i.desel();
  endtask : rd2

  initial
  begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk_st(8'h30);
    cmd1(SEC_OP_SET_WRITE_LATCH);
    chk_st(8'h32);
    rd_st(8'h32);
    cmd1(SEC_OP_SET_USER_FLAG);
    chk_st(8'h72);
    cmd1(SEC_OP_CLEAR_LATCH);
    chk_st(8'h30);
    wr_raw(1'b0, 16'h0010, 8'hA5, 0);
    chk_st(8'h30);
    wr_raw(1'b1, 16'h0010, 8'hA5, 0);
    chk_st(8'h30);
    cmd1(SEC_OP_SET_WRITE_LATCH);
    wr_raw(1'b0, 16'h0010, 8'hA5, 4);
    chk_st(8'h32);
    wr_raw(1'b0, 16'h0010, 8'hA5, 0);
    chk_st(8'h33);
    rd_st(8'h33);
    wait_idle();
    chk_st(8'h30);
    wr_arr(16'h0FFF, 8'h11);
    wr_arr(16'h0000, 8'h22);
    wr_arr(16'h0C00, 8'h5A);
    rd2(16'h0FFF, 8'h11, 8'h22);
    wr_stat(8'h34);
    chk_st(8'h34);
    wr_arr(16'h0C00, 8'hC3);
    wr_arr(16'h0BFF, 8'h77);
    rd2(16'h0BFF, 8'h77, 8'h5A);
    cmd1(SEC_OP_CLEAR_LATCH);
    wr_stat(8'hB0);
    chk_st(8'hB0);
    @(posedge clock);
    wp_n_pin <= 1'b0;
    wr_stat(8'h30);
    cmd1(SEC_OP_CLEAR_LATCH);
    chk_st(8'hB0);
    @(posedge clock);
    wp_n_pin <= 1'b1;
    wr_stat(8'h70);
    chk_st(8'h70);
    sec_spi_host_i.sel();
    tx8(8'hFF);
    tx8(8'h00);
    #1;
    chk({7'h00, so_oe}, 8'h00);
    sec_spi_host_i.desel();
    final_report();
  end

  initial
  begin
    repeat (90000) @(posedge clock);
    fail_count++;
    final_report();
  end
endmodule : tb_spi_eeprom_command_protect

bind sec_spi_front sec_spi_front_checker #(.WRITE_CYCLES(WRITE_CYCLES))
  sec_spi_front_checker_i (
  .clock(clock), .resetn(resetn), .cs_n_pin(cs_n_pin),
  .sck_pin(sck_pin), .si_pin(si_pin), .wp_n_pin(wp_n_pin),
  .so_out(so_out), .so_oe(so_oe),
  .protect_status_byte(protect_status_byte));
`default_nettype wire
